/* File: test/sbdt_agent_model.sv */
`timescale 1ns/1ns
// ****************************************
// external agent driving the inbound bus
// ****************************************
module sbdt_agent_model (
    input wire logic clk,
    output logic [31:0] ad,
    output logic [3:0] cb,
    output logic [8:0] cmd,
    output logic valid_n
);
    logic [34:0] q[$];
    // idle bus at time zero
    initial begin
        ad = 32'h0;
        cb = 4'h0;
        cmd = 9'h0;
        valid_n = 1'b1;
    end
    // one cycle, then gap cycles with the bus scrambled
    task automatic put(input logic [31:0] d, input logic [8:0] c,
        input logic bad, input int gap);
        ad <= d;
        cb <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} ^ {4{bad}};
        cmd <= c;
        valid_n <= 1'b0;
        @(posedge clk);
        repeat (gap) begin
            valid_n <= 1'b1;
            ad <= ~d;
            cmd <= ~c;
            @(posedge clk);
        end
    endtask
    // third-party traffic with valid held off
    task automatic foreign(input int n);
        repeat (n) begin
            ad <= $urandom();
            cmd <= 9'h100 | 9'($urandom());
            valid_n <= 1'b1;
            @(posedge clk);
        end
    endtask
    // eight-word response in XOR order from start doubleword st
    task automatic block(input logic [255:0] ln, input logic [1:0] st,
        input logic be, input int ew, input int bw, input logic nc);
        logic [31:0] d;
        for (int k = 0; k < 8; k++) begin
            d = ln[32 * ({k[2:1] ^ st, k[0]} ^ be) +: 32];
            q.push_back({k == 7, k == ew, k == bw && !nc, d});
            put(d, {1'b1, k != 7, 1'b0, k == ew, nc, 4'h0}, k == bw,
                k == 7 ? 1 : $urandom_range(0, 2));
        end
    endtask
endmodule

/* File: test/sbdt_top_checker.sv */
`timescale 1ns/1ns
// ****************************************
// port-level checks of the transfer layer
// ****************************************
module sbdt_top_checker (
    input logic clk,
    input logic sys_rst,
    input logic [31:0] addr_data_in,
    input logic [3:0] check_bit_in,
    input logic [8:0] command_id_in,
    input logic agent_valid_n,
    input logic [31:0] addr_data_out,
    input logic addr_data_oe_n,
    input logic valid_out_n,
    input logic rd_word_valid,
    input logic [31:0] rd_word,
    input logic rd_word_last,
    input logic line_invalidate,
    input logic bus_error,
    input logic cache_error,
    input logic external_error_flag,
    input logic slave_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] par;
    // even parity expected per byte lane
    assign par = {^addr_data_in[31:24], ^addr_data_in[23:16],
        ^addr_data_in[15:8], ^addr_data_in[7:0]};
    sequence s_take;
        !agent_valid_n && command_id_in[8];
    endsequence
    sequence s_par_bad;
        s_take ##0 (!command_id_in[4] && check_bit_in != par);
    endsequence
    a_err_bus_error: assert property (s_take ##0 command_id_in[5] |=> bus_error)
        else $error("bus error missing");
    a_take_word: assert property (s_take |=> rd_word_valid
        && rd_word == $past(addr_data_in)) else $error("word not taken");
    a_no_take: assert property (!(!agent_valid_n && command_id_in[8])
        |=> !rd_word_valid) else $error("word taken wrongly");
    a_last_flag: assert property (s_take |=> rd_word_last
        == !$past(command_id_in[7])) else $error("last flag wrong");
    a_parity_cache: assert property (s_par_bad
        |=> cache_error && external_error_flag) else $error("parity missed");
    a_nochk_quiet: assert property (s_take ##0 command_id_in[4]
        |=> !cache_error) else $error("unchecked word flagged");
    a_bad_inval: assert property ((s_take ##0 command_id_in[5]) or s_par_bad
        |=> line_invalidate) else $error("line not invalidated");
    a_slave_float: assert property (slave_state |-> addr_data_oe_n)
        else $error("bus driven in slave state");
    a_null_exit: assert property (slave_state && !agent_valid_n
        && command_id_in[8:3] == 6'h0C |=> !slave_state)
        else $error("null did not release");
    a_gap_hold: assert property (!valid_out_n ##1 (valid_out_n
        && !addr_data_oe_n) |-> $stable(addr_data_out))
        else $error("data not held");
endmodule

bind sbdt_top sbdt_top_checker sbdt_top_checker_inst(.clk(clk),
    .sys_rst(sys_rst), .addr_data_in(addr_data_in),
    .check_bit_in(check_bit_in), .command_id_in(command_id_in),
    .agent_valid_n(agent_valid_n), .addr_data_out(addr_data_out),
    .addr_data_oe_n(addr_data_oe_n), .valid_out_n(valid_out_n),
    .rd_word_valid(rd_word_valid), .rd_word(rd_word),
    .rd_word_last(rd_word_last), .line_invalidate(line_invalidate),
    .bus_error(bus_error), .cache_error(cache_error),
    .external_error_flag(external_error_flag), .slave_state(slave_state));

/* File: test/system_bus_data_transfer_test.sv */
`timescale 1ns/1ns
// ****************************************
// self-checking bench for the transfer layer
// ****************************************
module system_bus_data_transfer_test;
    logic clk, sys_rst, big_endian, agent_valid_n, release_to_slave;
    logic wr_start, cache_error_clear, addr_data_oe_n, valid_out_n, wr_busy;
    logic rd_word_valid, rd_word_last, line_invalidate, bus_error;
    logic cache_error, external_error_flag, slave_state;
    logic [3:0] write_pattern_select, check_bit_in, check_bit_out;
    logic [8:0] command_id_in, command_id_out;
    logic [31:0] addr_data_in, wr_addr, addr_data_out, rd_word;
    logic [255:0] wr_line, ln;
    logic [34:0] exp_w;
    int mismatches, check_count, seed_dummy;
    sbdt_top sbdt_top_inst(.clk(clk), .sys_rst(sys_rst),
        .big_endian(big_endian), .write_pattern_select(write_pattern_select),
        .addr_data_in(addr_data_in), .check_bit_in(check_bit_in),
        .command_id_in(command_id_in), .agent_valid_n(agent_valid_n),
        .release_to_slave(release_to_slave), .wr_start(wr_start),
        .wr_addr(wr_addr), .wr_line(wr_line),
        .cache_error_clear(cache_error_clear), .addr_data_out(addr_data_out),
        .check_bit_out(check_bit_out), .command_id_out(command_id_out),
        .addr_data_oe_n(addr_data_oe_n), .valid_out_n(valid_out_n),
        .wr_busy(wr_busy), .rd_word_valid(rd_word_valid), .rd_word(rd_word),
        .rd_word_last(rd_word_last), .line_invalidate(line_invalidate),
        .bus_error(bus_error), .cache_error(cache_error),
        .external_error_flag(external_error_flag), .slave_state(slave_state));
    sbdt_agent_model sbdt_agent_model_inst(.clk(clk), .ad(addr_data_in),
        .cb(check_bit_in), .cmd(command_id_in), .valid_n(agent_valid_n));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // slot offset of data word i for pattern row p
    function automatic int offs(input int p, input int i);
        int per[9] = '{1, 3, 4, 2, 5, 6, 3, 8, 4};
        int two[9] = '{0, 1, 1, 0, 1, 1, 0, 1, 0};
        return two[p] ? (i / 2) * per[p] + i % 2 : i * per[p];
    endfunction
    // even parity per byte lane
    function automatic logic [3:0] par_of(input logic [31:0] d);
        return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
    endfunction
    task automatic do_reset(input int p);
        sys_rst <= 1'b1;
        write_pattern_select <= 4'(p);
        repeat (10) @(posedge clk);
        check({valid_out_n, addr_data_oe_n, wr_busy, slave_state}, 4'hC);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic wait_slave(input logic v);
        for (int i = 0; i < 20 && slave_state !== v; i++) @(posedge clk);
        check({slave_state, addr_data_oe_n}, {v, v});
    endtask
    // block write with a refused second start, then a quiet tail
    task automatic bwrite(input int p);
        int t, n, first;
        logic [31:0] w;
        for (int i = 0; i < 8; i++) ln[32 * i +: 32] = $urandom();
        wr_addr <= $urandom() & 32'hFFFFFFE0;
        wr_line <= ln;
        wr_start <= 1'b1;
        n = 0;
        for (t = 0; t < 200 && n < 9; t++) begin
            @(posedge clk);
            wr_start <= (t == 2);
            if (valid_out_n === 1'b0) begin
                if (n == 0) begin
                    check({wr_busy, command_id_out, addr_data_out}, {1'b1,
                        1'b0, 3'h2, 2'h2, 1'b0, 2'h1, wr_addr});
                end else begin
                    if (n == 1) first = t;
                    w = ln[32 * ((n - 1) ^ int'(big_endian)) +: 32];
                    check({command_id_out[8:7], check_bit_out, w}, {1'b1,
                        n != 8, par_of(w), addr_data_out});
                    check(t - first, offs(p, n - 1));
                end
                n++;
            end
        end
        repeat (40) begin
            @(posedge clk);
            if (valid_out_n === 1'b0) n++;
        end
        check(n, 9);
        check(wr_busy, 1'b0);
    endtask
    // inbound words checked against the agent's record
    always @(posedge clk) begin
        if (rd_word_valid === 1'b1) begin
            exp_w = sbdt_agent_model_inst.q.size() ? sbdt_agent_model_inst.q.pop_front() : 35'h0;
            check({rd_word_last, bus_error, cache_error, rd_word}, exp_w);
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // main sequence
    initial begin
        {sys_rst, big_endian, release_to_slave, wr_start} = 4'h8;
        {cache_error_clear, write_pattern_select, wr_addr} = 37'h0;
        wr_line = 256'h0;
        mismatches = 0;
        check_count = 0;
        seed_dummy = $urandom(32'hB3236697);
        for (int p = 0; p < 9; p++) begin
            big_endian <= 1'(p);
            do_reset(p);
            bwrite(p);
            $display("block write pattern %0d done", p);
        end
        release_to_slave <= 1'b1;
        @(posedge clk);
        release_to_slave <= 1'b0;
        wait_slave(1'b1);
        sbdt_agent_model_inst.foreign(6);
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 8; i++) ln[32 * i +: 32] = $urandom();
            sbdt_agent_model_inst.block(ln, 2'(r), 1'($urandom()),
                r == 1 ? 3 : 9, r >= 2 ? 5 : 9, r == 3);
            $display("block read %0d done", r);
        end
        repeat (3) @(posedge clk);
        check(external_error_flag, 1'b1);
        cache_error_clear <= 1'b1;
        @(posedge clk);
        cache_error_clear <= 1'b0;
        repeat (2) @(posedge clk);
        check(external_error_flag, 1'b0);
        sbdt_agent_model_inst.put(32'h0, 9'h060, 1'b0, 1);
        wait_slave(1'b0);
        print_verdict();
    end
endmodule

/* File: verilog/sbdt_consts.svh */
`ifndef SBDT_CONSTS_SVH
`define SBDT_CONSTS_SVH

// ****************************************
// command / data identifier bit positions
// ****************************************
`define SBDT_CMD_W 9
`define SBDT_CMD_IS_DATA 8
`define SBDT_ID_LAST_N 7
`define SBDT_ID_RESP_N 6
`define SBDT_ID_ERR 5
`define SBDT_ID_NOCHK 4
`define SBDT_CMD_TYPE_HI 7
`define SBDT_CMD_TYPE_LO 5
`define SBDT_CMD_ATTR_HI 4
`define SBDT_CMD_ATTR_LO 3

// ****************************************
// command encodings
// ****************************************
`define SBDT_TYPE_READ 3'h0
`define SBDT_TYPE_WRITE 3'h2
`define SBDT_TYPE_NULL 3'h3
`define SBDT_ATTR_RELEASE 2'h0
`define SBDT_ATTR_BLOCK 2'h2
`define SBDT_ATTR_WORD 2'h3
`define SBDT_SIZE_8W 2'h1

// ****************************************
// sizes and pattern select
// ****************************************
`define SBDT_WORDS_PER_LINE 8
`define SBDT_PAT_NUM 9
`define SBDT_PAT_SEL_RST 4'h0

`endif

/* File: verilog/sbdt_pace_if.sv */
`timescale 1ns/1ns
// ****************************************
// pacing link between writer and pattern gen
// ****************************************
interface sbdt_pace_if;
    logic start;
    logic [3:0] sel;
    logic slot;
    modport gen (input start, input sel, output slot);
    modport user (output start, output sel, input slot);
endinterface

/* File: verilog/sbdt_pattern_gen.sv */
`timescale 1ns/1ns
`include "sbdt_consts.svh"
module sbdt_pattern_gen
    import sbdt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    sbdt_pace_if.gen pace
);
    logic [2:0] phase_ff;
    logic [2:0] period;
    logic pair;

    // ****************************************
    // period and words per period per pattern
    // ****************************************
    always_comb begin
        period = 3'h1;
        pair = 1'b0;
        unique case (pace.sel)
            4'h0: begin period = 3'h1; pair = 1'b0; end
            4'h1: begin period = 3'h3; pair = 1'b1; end
            4'h2: begin period = 3'h4; pair = 1'b1; end
            4'h3: begin period = 3'h2; pair = 1'b0; end
            4'h4: begin period = 3'h5; pair = 1'b1; end
            4'h5: begin period = 3'h6; pair = 1'b1; end
            4'h6: begin period = 3'h3; pair = 1'b0; end
            4'h7: begin period = 3'h0; pair = 1'b1; end // 8 cycles
            4'h8: begin period = 3'h4; pair = 1'b0; end
            default: begin period = 3'h1; pair = 1'b0; end
        endcase
    end

    // phase counter restarts on start
    always_ff @(posedge clk) begin
        if (sys_rst || pace.start) begin
            phase_ff <= 3'h0;
        end else if (phase_ff == period - 3'h1) begin
            phase_ff <= 3'h0;
        end else begin
            phase_ff <= phase_ff + 3'h1;
        end
    end

    // data slot on phase 0, and phase 1 for paired patterns
    assign pace.slot = pace.start || (phase_ff == 3'h0) ||
        (pair && phase_ff == 3'h1 && period != 3'h1);
endmodule

/* File: verilog/sbdt_pkg.sv */
package sbdt_pkg;
    typedef enum logic [1:0] {
        SBDT_IDLE,
        SBDT_ADDR,
        SBDT_DATA
    } sbdt_wr_state_e;
    typedef enum logic {
        SBDT_MASTER,
        SBDT_SLAVE
    } sbdt_own_e;
endpackage

/* File: verilog/sbdt_top.sv */
`timescale 1ns/1ns
`include "sbdt_consts.svh"
// How it works
// - bad or parity-failed doubleword invalidates line
// - erroneous-data identifier raises bus error
// - parity error raises cache error, sets flag
// - at most one word per clock
// - accept data only valid and identifier
// - block write follows nine boot patterns
// - unused pattern cycles hold previous data
// - 32-bit cycles, two clocks per doubleword
// - endianness picks word order in doubleword
// - single or partial word takes one clock
// - block write ascending, address first
// - release null request returns master state
// - nine-bit command, top bit marks data
// - identifier last, response, error bits
// - identifier bit four disables checking
module sbdt_top
    import sbdt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic big_endian,
    input wire logic [3:0] write_pattern_select,
    input wire logic [31:0] addr_data_in,
    input wire logic [3:0] check_bit_in,
    input wire logic [8:0] command_id_in,
    input wire logic agent_valid_n,
    input wire logic release_to_slave,
    input wire logic wr_start,
    input wire logic [31:0] wr_addr,
    input wire logic [255:0] wr_line,
    input wire logic cache_error_clear,
    output logic [31:0] addr_data_out,
    output logic [3:0] check_bit_out,
    output logic [8:0] command_id_out,
    output logic addr_data_oe_n,
    output logic valid_out_n,
    output logic wr_busy,
    output logic rd_word_valid,
    output logic [31:0] rd_word,
    output logic rd_word_last,
    output logic line_invalidate,
    output logic bus_error,
    output logic cache_error,
    output logic external_error_flag,
    output logic slave_state
);
    sbdt_pace_if pace ();
    sbdt_pattern_gen u_pat (
        .clk(clk),
        .sys_rst(sys_rst),
        .pace(pace)
    );

    // ****************************************
    // receive path
    // ****************************************
    logic data_cyc;
    logic par_bad;
    logic chk_en;
    logic id_err;
    logic half_ff;
    logic dw_bad_ff;
    logic [3:0] pat_sel_ff;

    // data cycle qualification
    assign data_cyc = !agent_valid_n &&
        command_id_in[`SBDT_CMD_IS_DATA];
    assign id_err = command_id_in[`SBDT_ID_ERR];
    assign chk_en = !command_id_in[`SBDT_ID_NOCHK];

    // even parity per byte lane
    genvar gi;
    logic [3:0] lane_bad;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_par
            assign lane_bad[gi] = ^{addr_data_in[gi*8 +: 8],
                check_bit_in[gi]};
        end
    endgenerate
    assign par_bad = |lane_bad;

    // word handed up, one per clock at most
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_word_valid <= 1'b0;
            rd_word <= 32'h0;
            rd_word_last <= 1'b0;
        end else begin
            rd_word_valid <= data_cyc;
            rd_word_last <= data_cyc &&
                !command_id_in[`SBDT_ID_LAST_N];
            if (data_cyc) begin
                rd_word <= addr_data_in;
            end
        end
    end

    // doubleword halves of a block response
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            half_ff <= 1'b0;
            dw_bad_ff <= 1'b0;
        end else if (data_cyc) begin
            if (!command_id_in[`SBDT_ID_LAST_N]) begin
                half_ff <= 1'b0;
            end else begin
                half_ff <= !half_ff;
            end
            dw_bad_ff <= !half_ff && (id_err || (chk_en && par_bad));
        end
    end

    // ****************************************
    // line invalidation
    // ****************************************
    // invalidate when either half of doubleword is bad
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            line_invalidate <= 1'b0;
        end else begin
            line_invalidate <= data_cyc &&
                !command_id_in[`SBDT_ID_RESP_N] &&
                (id_err || (chk_en && par_bad) ||
                (half_ff && dw_bad_ff));
        end
    end

    // ****************************************
    // exception pulses
    // ****************************************
    // exceptions
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_error <= 1'b0;
            cache_error <= 1'b0;
        end else begin
            bus_error <= data_cyc &&
                !command_id_in[`SBDT_ID_RESP_N] && id_err;
            cache_error <= data_cyc && chk_en && par_bad;
        end
    end

    // ****************************************
    // cache error status
    // ****************************************
    // sticky external error flag, set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            external_error_flag <= 1'b0;
        end else if (data_cyc && chk_en && par_bad) begin
            external_error_flag <= 1'b1;
        end else if (cache_error_clear) begin
            external_error_flag <= 1'b0;
        end
    end

    // ****************************************
    // bus ownership
    // ****************************************
    logic null_rel;
    assign null_rel = !agent_valid_n &&
        !command_id_in[`SBDT_CMD_IS_DATA] &&
        command_id_in[`SBDT_CMD_TYPE_HI:`SBDT_CMD_TYPE_LO] ==
        `SBDT_TYPE_NULL &&
        command_id_in[`SBDT_CMD_ATTR_HI:`SBDT_CMD_ATTR_LO] ==
        `SBDT_ATTR_RELEASE;

    // slave until release null seen; enable moves with state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slave_state <= 1'b0;
            addr_data_oe_n <= 1'b1;
        end else if (null_rel) begin
            slave_state <= 1'b0;
            addr_data_oe_n <= 1'b0;
        end else if (release_to_slave) begin
            slave_state <= 1'b1;
            addr_data_oe_n <= 1'b1;
        end else begin
            addr_data_oe_n <= slave_state;
        end
    end

    // ****************************************
    // block write transmitter
    // ****************************************
    sbdt_wr_state_e st_ff;
    logic [2:0] wcnt_ff;
    logic [255:0] line_ff;
    logic [31:0] addr_ff;
    logic [2:0] widx;
    logic [31:0] wword;

    // ****************************************
    // boot pattern capture
    // ****************************************
    // pattern latched once at boot
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pat_sel_ff <= `SBDT_PAT_SEL_RST;
        end else if (st_ff == SBDT_IDLE && !wr_busy) begin
            pat_sel_ff <= pat_sel_ff;
        end
    end

    logic boot_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boot_ff <= 1'b1;
        end else begin
            boot_ff <= 1'b0;
        end
    end

    logic [3:0] boot_sel_ff;
    always_ff @(posedge clk) begin
        if (boot_ff) begin
            boot_sel_ff <= write_pattern_select;
        end
    end

    assign pace.sel = boot_ff ? pat_sel_ff : boot_sel_ff;
    // pattern phase restarts so the first data cycle is phase 0
    assign pace.start = (st_ff == SBDT_ADDR);

    // ****************************************
    // word selection
    // ****************************************
    // word order: ascending doublewords, halves by endianness
    assign widx = {wcnt_ff[2:1], wcnt_ff[0] ^ big_endian};
    assign wword = line_ff[widx*32 +: 32];

    // ****************************************
    // write sequencer
    // ****************************************
    // sequencer; starts refused while busy or slave
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= SBDT_IDLE;
            wcnt_ff <= 3'h0;
            line_ff <= 256'h0;
            addr_ff <= 32'h0;
            wr_busy <= 1'b0;
        end else begin
            unique case (st_ff)
                SBDT_IDLE: begin
                    if (wr_start && !slave_state) begin
                        st_ff <= SBDT_ADDR;
                        line_ff <= wr_line;
                        addr_ff <= wr_addr;
                        wcnt_ff <= 3'h0;
                        wr_busy <= 1'b1;
                    end
                end
                SBDT_ADDR: begin
                    st_ff <= SBDT_DATA;
                end
                SBDT_DATA: begin
                    if (pace.slot) begin
                        if (wcnt_ff == 3'h7) begin
                            st_ff <= SBDT_IDLE;
                            wr_busy <= 1'b0;
                        end else begin
                            wcnt_ff <= wcnt_ff + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************
    // outbound bus drive
    // ****************************************
    // bus drive; data held steady in unused cycles
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_data_out <= 32'h0;
            command_id_out <= 9'h0;
            valid_out_n <= 1'b1;
            check_bit_out <= 4'h0;
        end else begin
            valid_out_n <= 1'b1;
            if (st_ff == SBDT_ADDR) begin
                addr_data_out <= addr_ff;
                command_id_out <= {1'b0, `SBDT_TYPE_WRITE,
                    `SBDT_ATTR_BLOCK, 1'b0, `SBDT_SIZE_8W};
                valid_out_n <= 1'b0;
            end else if (st_ff == SBDT_DATA && pace.slot) begin
                addr_data_out <= wword;
                command_id_out <= {1'b1, wcnt_ff != 3'h7, 1'b1,
                    6'h00};
                check_bit_out <= {^wword[31:24], ^wword[23:16],
                    ^wword[15:8], ^wword[7:0]};
                valid_out_n <= 1'b0;
            end // else hold
        end
    end
endmodule
